// ### src/csp_pkg.sv
// Package for the closed-loop speed controller: register map, fields,
// reset values and timing constants.
// Assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus.
package csp_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int TICK_W = 18;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // Register byte offsets
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_CMD = 6'h04;
    localparam logic [5:0] REG_MAXRPM = 6'h08;
    localparam logic [5:0] REG_KP = 6'h0c;
    localparam logic [5:0] REG_KI = 6'h10;
    localparam logic [5:0] REG_KD = 6'h14;
    localparam logic [5:0] REG_ILIM = 6'h18;
    localparam logic [5:0] REG_STATUS = 6'h1c;
    localparam logic [5:0] REG_SPEED = 6'h20;
    localparam logic [5:0] REG_SPREL = 6'h24;
    localparam logic [5:0] REG_POS = 6'h28;
    localparam logic [5:0] REG_ERR = 6'h2c;
    localparam logic [5:0] REG_DEST = 6'h30;

    // Control fields
    localparam int CTRL_MODE_LO = 0;
    localparam int CTRL_MODE_HI = 1;
    localparam int CTRL_RELCMD = 2;
    localparam int CTRL_SENS_LO = 4;
    localparam int CTRL_SENS_HI = 5;
    localparam int CTRL_STOP = 8;

    localparam logic [31:0] MAXRPM_RESET = 32'h0000_0bb8;
    localparam logic [15:0] KP_RESET = 16'h0000;
    localparam logic [15:0] KI_RESET = 16'h0001;
    localparam logic [15:0] KD_RESET = 16'h0000;
    localparam logic [31:0] ILIM_RESET = 32'h0010_0000;

    localparam logic signed [31:0] REL_FULL = 32'sd1000;
    localparam int GAIN_SHIFT = 8;
    localparam logic signed [15:0] PWR_MAX = 16'sd1000;

    // Sensitivity thresholds and durations in ms
    localparam logic [31:0] ERR_TH1 = 32'd100;
    localparam logic [31:0] ERR_TH2 = 32'd250;
    localparam logic [31:0] ERR_TH3 = 32'd500;
    localparam logic [10:0] ERR_MS1 = 11'd250;
    localparam logic [10:0] ERR_MS2 = 11'd500;
    localparam logic [10:0] ERR_MS3 = 11'd1000;

    localparam int HALL_PER_W = 24;
    localparam logic [HALL_PER_W-1:0] HALL_PER_MAX = 24'hffffff;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        CSP_OPEN,
        CSP_SPEED,
        CSP_SPEED_POS,
        CSP_RSVD
    } csp_mode_t;
endpackage

// ### src/csp_hall_speed.sv
// Hall transition speed meter with 32-bit up/down position counter.
// Assumes hall inputs are synchronous to aclk and already debounced.
`timescale 1ns/100ps
module csp_hall_speed
    import csp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] hall,
    input wire logic signed [31:0] rpm_k,
    output logic signed [31:0] position,
    output logic signed [31:0] rpm
);
    logic [2:0] hall_q;
    logic [HALL_PER_W-1:0] period_cnt;
    logic dir_fwd;
    logic step;
    logic fwd;

    assign step = (hall != hall_q);
    // Forward when the new state is the successor in the 1-3-2-6-4-5 cycle
    always_comb begin
        case (hall_q)
            3'h1: fwd = (hall == 3'h3);
            3'h3: fwd = (hall == 3'h2);
            3'h2: fwd = (hall == 3'h6);
            3'h6: fwd = (hall == 3'h4);
            3'h4: fwd = (hall == 3'h5);
            3'h5: fwd = (hall == 3'h1);
            default: fwd = 1'b1;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hall_q <= 3'h0;
        end else begin
            hall_q <= hall;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            position <= 32'sh0;
        end else if (step && hall_q != 3'h0) begin
            position <= fwd ? position + 32'sh1 : position - 32'sh1; // [R16]
        end
    end

    // Speed from the interval between transitions; a stall saturates to 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_cnt <= '0;
            rpm <= 32'sh0;
            dir_fwd <= 1'b1;
        end else if (step) begin
            // Start at one so the interval includes its closing edge
            period_cnt <= HALL_PER_W'(1); // [R1]
            dir_fwd <= fwd;
            if (period_cnt != '0) begin
                rpm <= fwd ? rpm_k / $signed({8'h00, period_cnt})
                           : -(rpm_k / $signed({8'h00, period_cnt})); // [R16] [R1]
            end
        end else if (period_cnt != HALL_PER_MAX) begin
            period_cnt <= period_cnt + 1'b1;
        end else begin
            rpm <= 32'sh0;
        end
    end
endmodule

// ### src/csp_speed_pid.sv
// Closed-loop speed and speed-position controller for one motor channel.
// Assumes an AXI4-Lite master, hall sensor inputs and a power stage that
// takes a signed power level of -1000..+1000.
// Overview of operation
// R1: Measured speed is reported as true motor RPM from the hall timing.
// R2: Analog or pulse commands are relative values from -1000 to +1000.
// R3: Relative speed report scales the maximum RPM setting to 1000.
// R4: A relative command of 1000 targets the maximum RPM, pro rata below.
// R5: Link commands may be relative or absolute RPM, chosen by a flag.
// R6: Every millisecond the loop error is target minus measured value.
// R7: The proportional term is error times the proportional gain.
// R8: The differential term is the error change times its gain.
// R9: The integral term sums error and is scaled by its gain.
// R10: The integral sum is clamped by a configurable limit.
// R11: Speed-position mode advances a destination each ms by the speed.
// R12: The destination pauses while the motor lags the trajectory.
// R13: A fault follows error over 100/250/500 for 250/500/1000 ms.
// R14: A fault forces zero power until the error goes or open loop.
// R15: A stop command clears an active loop fault.
// R16: Hall speed comes from transition spacing; a 32-bit counter tracks.
// R17: The fault timer restarts whenever the error falls to the threshold.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
module csp_speed_pid
    import csp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic signed [15:0] analog_cmd,
    input wire logic analog_sel,
    input wire logic [2:0] hall,
    output logic signed [15:0] motor_power,
    output logic loop_fault
);
    logic [31:0] ctrl;
    logic signed [31:0] cmd;
    logic [31:0] max_rpm;
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] kd;
    logic [31:0] ilim;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic signed [31:0] meas_rpm;
    logic signed [31:0] position;
    logic signed [31:0] rel_speed;
    logic signed [31:0] target;
    logic signed [31:0] dest;
    logic signed [31:0] err;
    logic signed [31:0] prev_err;
    logic signed [31:0] integ;
    logic signed [31:0] next_err;
    logic signed [31:0] next_integ;
    logic signed [63:0] pid_sum;
    logic [31:0] err_mag;
    logic [31:0] err_th;
    logic [10:0] err_ms_lim;
    logic [10:0] err_ms;
    logic stop_req;
    logic lagging;
    logic [31:0] rdata_mux;
    logic addr_ok;
    logic [63:0] rel_prod;
    logic signed [31:0] sel_cmd;
    logic signed [31:0] rpm_k;
    csp_mode_t mode;

    assign mode = csp_mode_t'(ctrl[CTRL_MODE_HI:CTRL_MODE_LO]);

    csp_hall_speed u_hall (
        .aclk(aclk),
        .aresetn(aresetn),
        .hall(hall),
        .rpm_k(rpm_k),
        .position(position),
        .rpm(meas_rpm)
    );
    // Cycles per minute over six steps per electrical turn
    assign rpm_k = 32'(CLK_HZ / 6 * 60 / 1000) * 32'sd1000;

    // Write channel: address and data taken in either order
    logic aw_held;
    logic w_held;
    logic [5:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    logic wr_ok;
    always_comb begin
        if (aw_addr == REG_CTRL) wr_ok = 1'b1;
        else if (aw_addr == REG_CMD) wr_ok = 1'b1;
        else if (aw_addr == REG_MAXRPM) wr_ok = 1'b1;
        else if (aw_addr == REG_KP) wr_ok = 1'b1;
        else if (aw_addr == REG_KI) wr_ok = 1'b1;
        else if (aw_addr == REG_KD) wr_ok = 1'b1;
        else if (aw_addr == REG_ILIM) wr_ok = 1'b1;
        else wr_ok = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= '0;
            cmd <= '0;
            max_rpm <= MAXRPM_RESET;
            kp <= KP_RESET;
            ki <= KI_RESET;
            kd <= KD_RESET;
            ilim <= ILIM_RESET;
            stop_req <= 1'b0;
        end else begin
            stop_req <= 1'b0;
            if (do_write) begin
                if (aw_addr == REG_CTRL) begin
                    ctrl <= merge(ctrl, w_data, w_strb) & ~(32'h1 << CTRL_STOP);
                    stop_req <= w_strb[1] && w_data[CTRL_STOP]; // [R15]
                end else if (aw_addr == REG_CMD) begin
                    cmd <= merge(cmd, w_data, w_strb);
                end else if (aw_addr == REG_MAXRPM) begin
                    max_rpm <= merge(max_rpm, w_data, w_strb);
                end else if (aw_addr == REG_KP) begin
                    kp <= 16'(merge({16'h0, kp}, w_data, w_strb));
                end else if (aw_addr == REG_KI) begin
                    ki <= 16'(merge({16'h0, ki}, w_data, w_strb));
                end else if (aw_addr == REG_KD) begin
                    kd <= 16'(merge({16'h0, kd}, w_data, w_strb));
                end else if (aw_addr == REG_ILIM) begin
                    ilim <= merge(ilim, w_data, w_strb);
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel
    always_comb begin
        addr_ok = 1'b1;
        if (s_axi_araddr == REG_CTRL) rdata_mux = ctrl;
        else if (s_axi_araddr == REG_CMD) rdata_mux = cmd;
        else if (s_axi_araddr == REG_MAXRPM) rdata_mux = max_rpm;
        else if (s_axi_araddr == REG_KP) rdata_mux = {16'h0, kp};
        else if (s_axi_araddr == REG_KI) rdata_mux = {16'h0, ki};
        else if (s_axi_araddr == REG_KD) rdata_mux = {16'h0, kd};
        else if (s_axi_araddr == REG_ILIM) rdata_mux = ilim;
        else if (s_axi_araddr == REG_STATUS) rdata_mux = {30'h0, lagging, loop_fault};
        else if (s_axi_araddr == REG_SPEED) rdata_mux = meas_rpm; // [R1]
        else if (s_axi_araddr == REG_SPREL) rdata_mux = rel_speed;
        else if (s_axi_araddr == REG_POS) rdata_mux = position;
        else if (s_axi_araddr == REG_ERR) rdata_mux = err;
        else if (s_axi_araddr == REG_DEST) rdata_mux = dest;
        else begin
            rdata_mux = 32'h0;
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_mux;
            s_axi_rresp <= addr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) s_axi_rvalid <= 1'b0;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Speed scaling; max RPM of zero reads as zero to avoid a divide by 0
    assign rel_speed = (max_rpm == 32'h0) ? 32'sh0
                     : 32'((64'(meas_rpm) * 64'(REL_FULL))
                       / $signed({32'h0, max_rpm})); // [R3]
    // Analog is always relative, register command may be either
    assign sel_cmd = analog_sel ? 32'(analog_cmd) : cmd; // [R2] [R5]
    assign rel_prod = 64'(sel_cmd) * $signed({32'h0, max_rpm});
    assign target = (analog_sel || ctrl[CTRL_RELCMD])
                  ? 32'($signed(rel_prod) / 64'(REL_FULL)) : cmd; // [R4] [R5]

    // One millisecond loop tick
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_cnt == TICK_LAST);
            tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'b1;
        end
    end

    // Lag: position error already larger than one period of travel
    assign lagging = (mode == CSP_SPEED_POS) &&
                     ((target >= 0) ? (dest - position > target)
                                    : (dest - position < target));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dest <= '0;
        end else if (mode != CSP_SPEED_POS) begin
            dest <= position;
        end else if (tick && !loop_fault && !lagging) begin // [R12]
            dest <= dest + target; // [R11]
        end
    end

    // PID arithmetic
    always_comb begin
        next_err = (mode == CSP_SPEED_POS) ? dest - position
                                           : target - meas_rpm; // [R6] [R11]
        next_integ = integ + next_err; // [R9]
        if (next_integ > $signed(ilim)) next_integ = $signed(ilim); // [R10]
        if (next_integ < -$signed(ilim)) next_integ = -$signed(ilim); // [R10]
        pid_sum = (64'(next_err) * 64'($signed({1'b0, kp}))
                + 64'(next_err - err) * 64'($signed({1'b0, kd}))
                + 64'(next_integ) * 64'($signed({1'b0, ki})))
                >>> GAIN_SHIFT; // [R7] [R8] [R9]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err <= '0;
            prev_err <= '0;
            integ <= '0;
            motor_power <= '0;
        end else if (mode == CSP_OPEN || loop_fault) begin
            err <= '0;
            integ <= '0;
            if (mode != CSP_OPEN) motor_power <= '0; // [R14]
            else if (target > 32'(PWR_MAX)) motor_power <= PWR_MAX;
            else if (target < -32'(PWR_MAX)) motor_power <= -PWR_MAX;
            else motor_power <= 16'(target);
        end else if (tick) begin // [R6]
            prev_err <= err;
            err <= next_err; // [R8]
            integ <= next_integ;
            if (pid_sum > 64'(PWR_MAX)) motor_power <= PWR_MAX;
            else if (pid_sum < -64'(PWR_MAX)) motor_power <= -PWR_MAX;
            else motor_power <= 16'(pid_sum); // [R7]
        end
    end

    // Loop error supervision
    always_comb begin
        case (ctrl[CTRL_SENS_HI:CTRL_SENS_LO])
            2'd1: begin err_th = ERR_TH1; err_ms_lim = ERR_MS1; end
            2'd2: begin err_th = ERR_TH2; err_ms_lim = ERR_MS2; end
            2'd3: begin err_th = ERR_TH3; err_ms_lim = ERR_MS3; end
            default: begin err_th = 32'hffff_ffff; err_ms_lim = ERR_MS3; end
        endcase
    end
    assign err_mag = next_err[31] ? 32'(-next_err) : 32'(next_err);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_ms <= '0;
        end else if (mode == CSP_OPEN || loop_fault) begin
            err_ms <= '0;
        end else if (tick) begin
            if (err_mag > err_th) err_ms <= err_ms + 1'b1; // [R13]
            else err_ms <= '0; // [R17]
        end
    end

    // Fault set wins over a stop arriving in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            loop_fault <= 1'b0;
        end else if (tick && mode != CSP_OPEN && err_mag > err_th
                     && err_ms + 1'b1 >= err_ms_lim) begin
            loop_fault <= 1'b1; // [R13]
        end else if (stop_req || mode == CSP_OPEN
                     || (tick && err_mag <= err_th)) begin
            loop_fault <= 1'b0; // [R15] [R14]
        end
    end
endmodule

// ### dv/csp_speed_pid_assertions.sv
// Port-level checker for the closed-loop speed controller.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module csp_speed_pid_assertions
    import csp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic signed [15:0] motor_power,
    input wire logic loop_fault
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Only same-cycle address and data handshakes are judged here
    wire aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("Write response dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("Read data dropped early");
    property p_b_resp;
        aw_hs && s_axi_awaddr < 6'h1c |->
            ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_OKAY;
    endproperty
    a_b_resp: assert property (p_b_resp)
        else $error("Writable register write not answered OKAY");
    property p_ro_err;
        aw_hs && s_axi_awaddr >= 6'h1c |->
            ##[1:3] s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
    endproperty
    a_ro_err: assert property (p_ro_err)
        else $error("Read-only or unmapped write not refused");
    property p_r_resp;
        ar_hs |=> s_axi_rvalid;
    endproperty
    a_r_resp: assert property (p_r_resp)
        else $error("Read data late");
    property p_rd_err;
        ar_hs && s_axi_araddr > 6'h30 |=>
            s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rd_err: assert property (p_rd_err)
        else $error("Unmapped read not refused");
    property p_pwr_lim;
        motor_power <= PWR_MAX && motor_power >= -PWR_MAX;
    endproperty
    a_pwr_lim: assert property (p_pwr_lim)
        else $error("Power beyond full scale");
    // One cycle of grace: power is forced from the registered fault
    property p_fault_pwr;
        loop_fault && $past(loop_fault) |-> motor_power == 16'sh0;
    endproperty
    a_fault_pwr: assert property (p_fault_pwr)
        else $error("Power applied during loop fault");
    c_wr: cover property (aw_hs);
    c_rd_err: cover property (ar_hs && s_axi_araddr > 6'h30);
    c_neg: cover property (motor_power < 16'sh0);
endmodule

// ### dv/csp_motor_model.sv
// Motor with hall sensor: steps the six hall codes at a set pace.
// Assumes a synchronous reset and a step period above one cycle.
`timescale 1ns/100ps
module csp_motor_model
    import csp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic dir,
    input wire logic [15:0] period,
    output logic [2:0] hall,
    output int steps
);
    localparam logic [17:0] SEQ = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    logic [2:0] idx = 3'h0;
    logic [15:0] cnt = 16'h0;
    assign hall = SEQ[3*idx +: 3];
    // Net step count is the reference the position counter must match
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt <= 16'h0;
        end else if (cnt == period - 16'h1) begin
            cnt <= 16'h0;
            idx <= dir ? ((idx == 3'h0) ? 3'h5 : idx - 3'h1)
                       : ((idx == 3'h5) ? 3'h0 : idx + 3'h1);
        end else begin
            cnt <= cnt + 16'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            steps <= 0;
        end else if (run && cnt == period - 16'h1) begin
            steps <= dir ? steps - 1 : steps + 1;
        end
    end
endmodule

// ### dv/tb_top.sv
// Self-checking bench: register bus, open-loop commands, hall feedback.
// Assumes the loop tick is too long to reach within the run.
`timescale 1ns/100ps
module tb_top;
    import csp_pkg::*;
    logic aclk = 0;
    logic aresetn = 0;
    logic [5:0] awa = 0, ara = 0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, asel = 0;
    logic run = 0, dir = 0;
    logic [31:0] wd = 0, rd, v;
    logic signed [15:0] acmd = 0, pwr;
    logic awr, wr, bv, arr, rv, fault;
    logic [1:0] bresp, rresp, r;
    logic [2:0] hall;
    logic signed [15:0] cmds [5] = '{500, -1000, 1000, 0, -1};
    int steps, err_count = 0, compares = 0, cyc = 0;

    always #2.5 aclk = ~aclk;

    csp_speed_pid dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .analog_cmd(acmd),
        .analog_sel(asel), .hall(hall), .motor_power(pwr),
        .loop_fault(fault));
    csp_motor_model mot_u (.aclk(aclk), .aresetn(aresetn), .run(run),
        .dir(dir), .period(16'd200), .hall(hall), .steps(steps));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic near(input logic signed [31:0] got, input int exp);
        logic signed [31:0] d;
        d = got - exp;
        compares++;
        // Speed comes from step spacing, so allow a 5 percent spread
        if ((d * 20 <= exp && d * 20 >= -exp) !== 1'b1 &&
            (d * 20 >= exp && d * 20 <= -exp) !== 1'b1) begin
            err_count++;
            $display("[ERR] %0t got %0d near %0d", $time, got, exp);
        end
    endtask
    task automatic wr32(input logic [5:0] a, input logic [31:0] d,
                        input logic [1:0] er);
        bit ad, wdn;
        ad = 0;
        wdn = 0;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        br <= 1;
        while (!(ad && wdn)) begin
            @(posedge aclk);
            if (!ad && awr === 1'b1) begin
                ad = 1;
                awv <= 0;
            end
            if (!wdn && wr === 1'b1) begin
                wdn = 1;
                wv <= 0;
            end
        end
        do @(posedge aclk); while (bv !== 1'b1);
        br <= 0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd32(input logic [5:0] a);
        @(posedge aclk);
        ara <= a;
        arv <= 1;
        rr <= 1;
        do @(posedge aclk); while (arr !== 1'b1);
        arv <= 0;
        do @(posedge aclk); while (rv !== 1'b1);
        v = rd;
        r = rresp;
        rr <= 0;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        rd32(a);
        chk(v, e);
    endtask
    task automatic pchk(input logic signed [15:0] e);
        for (int i = 0; i < 64 && pwr !== e; i++) @(posedge aclk);
        chk(32'(pwr), 32'(e));
    endtask
    task automatic close_out;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Run takes under 10000 cycles; the ceiling leaves ample margin
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            close_out;
        end
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rchk(REG_CTRL, 32'h0);
        rchk(REG_MAXRPM, MAXRPM_RESET);
        rchk(REG_KP, 32'(KP_RESET));
        rchk(REG_KI, 32'(KI_RESET));
        rchk(REG_KD, 32'(KD_RESET));
        rchk(REG_ILIM, ILIM_RESET);
        rchk(REG_STATUS, 32'h0);
        rchk(6'h34, 32'h0);
        chk(32'(r), 32'(RESP_SLVERR));
        wr32(REG_STATUS, 32'hffffffff, RESP_SLVERR);
        rchk(REG_STATUS, 32'h0);
        wr32(6'h3c, 32'h1, RESP_SLVERR);
        wr32(REG_ILIM, 32'h55, RESP_OKAY);
        rchk(REG_ILIM, 32'h55);
        wr32(REG_CTRL, 32'h134, RESP_OKAY);
        rchk(REG_CTRL, 32'h34);
        wr32(REG_CTRL, 32'h0, RESP_OKAY);
        // Max of 500: relative targets halve, absolute ones do not
        wr32(REG_MAXRPM, 32'd500, RESP_OKAY);
        asel <= 1;
        foreach (cmds[i]) begin
            acmd <= cmds[i];
            pchk(16'(cmds[i] / 2));
        end
        asel <= 0;
        wr32(REG_CTRL, 32'h4, RESP_OKAY);
        wr32(REG_CMD, -32'sd700, RESP_OKAY);
        pchk(-16'sd350);
        wr32(REG_CTRL, 32'h0, RESP_OKAY);
        wr32(REG_CMD, 32'd250, RESP_OKAY);
        pchk(16'sd250);
        chk(32'(fault), 32'h0);
        wr32(REG_MAXRPM, 32'd10_000_000, RESP_OKAY);
        run <= 1;
        repeat (2400) @(posedge aclk);
        rd32(REG_SPEED);
        near(v, 10_000_000);
        rd32(REG_SPREL);
        near(v, 1000);
        run <= 0;
        repeat (20) @(posedge aclk);
        rchk(REG_POS, 32'(steps));
        dir <= 1;
        run <= 1;
        repeat (2400) @(posedge aclk);
        rd32(REG_SPEED);
        near(v, -10_000_000);
        run <= 0;
        repeat (20) @(posedge aclk);
        rchk(REG_POS, 32'(steps));
        close_out;
    end
endmodule

bind csp_speed_pid csp_speed_pid_assertions chk_u (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .motor_power(motor_power), .loop_fault(loop_fault));
